/* File: verilog/first_fault_pkg.sv */
// Constants and types shared by the first-fault identifier recorder
`default_nettype none
package first_fault_pkg;
   // Flag vector, identifier, register, address and non-volatile address sizes
   localparam int NUM_FLAGS = 15;
   localparam int ID_W      = 4;
   localparam int REG_W     = 8;
   localparam int ADDR_W    = 16;
   localparam int NVM_AW    = 8;

   // Register addresses on the extended command space
   localparam logic [ADDR_W-1:0] ADDR_CFG  = 16'hFE08;
   localparam logic [ADDR_W-1:0] ADDR_FF_A = 16'hFECA;
   localparam logic [ADDR_W-1:0] ADDR_FF_B = 16'hFECB;

   // Configuration register layout and reset value
   localparam int               CFG_RECORD_BIT = 5;
   localparam logic [REG_W-1:0] CFG_RESET      = 8'h00;

   // Store register layout: current code low, previous code high
   localparam int CUR_LSB  = 0;
   localparam int PREV_LSB = 4;

   // Non-volatile slots holding each channel's store byte
   localparam logic [NVM_AW-1:0] NVM_ADDR_A = 8'h00;
   localparam logic [NVM_AW-1:0] NVM_ADDR_B = 8'h01;

   // Capturable flag positions; lower index wins a tie, code is index plus one
   localparam int FLG_OVERVOLT_A = 0;
   localparam int FLG_OVERVOLT_B = 1;
   localparam int FLG_UNDERVOLT_A = 2;
   localparam int FLG_UNDERVOLT_B = 3;
   localparam int FLG_INPUT_SENSE = 4;
   localparam int FLG_OVERCUR_C = 5;
   localparam int FLG_FASTCUR_A = 6;
   localparam int FLG_FASTCUR_B = 7;
   localparam int FLG_AVGCUR_A = 8;
   localparam int FLG_AVGCUR_B = 9;
   localparam int FLG_OVERTEMP_ONE = 10;
   localparam int FLG_OVERTEMP_TWO = 11;
   localparam int FLG_EXTERNAL = 12;
   localparam int FLG_REVERSE_A = 13;
   localparam int FLG_REVERSE_B = 14;

   // Configured response of a flag
   typedef enum logic [1:0] {
      ACT_NONE    = 2'b00,
      ACT_DIS_A   = 2'b01,
      ACT_DIS_B   = 2'b10,
      ACT_DIS_ALL = 2'b11
   } action_t;

   // Configured resolution after the flag clears
   typedef enum logic [1:0] {
      RES_IMMEDIATE = 2'b00,
      RES_DELAY_SS  = 2'b01,
      RES_SUPPLY_SS = 2'b10,
      RES_SPARE     = 2'b11
   } resolve_t;

   // Non-volatile access sequencer states
   typedef enum logic [1:0] {
      NV_IDLE  = 2'b00,
      NV_LOAD  = 2'b01,
      NV_STORE = 2'b10
   } nvm_state_t;
endpackage
`default_nettype wire

/* File: verilog/fault_id_slot.sv */
// One channel's current and previous first-fault identifier store
`timescale 1ns/1ps
`default_nettype none
module fault_id_slot #(
   parameter int NUM_FLAGS = 15,
   parameter int ID_W      = 4
) (
   input  wire logic                 ref_clk,        // System clock
   input  wire logic                 rst,            // Async reset, active high
   input  wire logic                 recordEnable,   // Recording enabled
   input  wire logic                 channelRunning, // Channel outputs enabled
   input  wire logic [NUM_FLAGS-1:0] qualify,        // Flags that shut this channel
   input  wire logic                 loadStrobe,     // Power-on reload pulse
   input  wire logic [ID_W-1:0]      loadId,         // Saved identifier
   output logic      [ID_W-1:0]      curId,          // Current identifier
   output logic      [ID_W-1:0]      prevId,         // Previous identifier
   output logic                      captured        // Capture pulse
);
   logic            armed;
   logic            runningDly;
   logic            doCapture;
   logic            runningRise;
   logic [ID_W-1:0] pickedId;

   // Lowest flag position wins when several assert together
   function automatic logic [ID_W-1:0] pick(input logic [NUM_FLAGS-1:0] v);
      logic [ID_W-1:0] id;
      id = '0;
      for (int i = NUM_FLAGS - 1; i >= 0; i--) begin
         if (v[i]) begin
            id = ID_W'(i + 1);
         end
      end
      return id;
   endfunction

   // Capture decision and chosen code
   assign pickedId    = pick(qualify);
   assign runningRise = channelRunning & ~runningDly;
   assign doCapture   = recordEnable & armed & (|qualify) & ~loadStrobe;

   // Arming: cleared by a capture, set again once the channel restarts
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         armed      <= 1'b1;
         runningDly <= 1'b0;
      end else begin
         runningDly <= channelRunning;
         if (doCapture) begin
            armed <= 1'b0;
         end else if (runningRise || loadStrobe) begin
            armed <= 1'b1;
         end
      end
   end

   // Store update: reload or shift on capture, otherwise hold
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         curId    <= '0;
         prevId   <= '0;
         captured <= 1'b0;
      end else begin
         captured <= doCapture;
         if (loadStrobe) begin
            curId  <= loadId;
            prevId <= loadId;
         end else if (doCapture) begin
            prevId <= curId;
            curId  <= pickedId;
         end
      end
   end

   a_capture_shift: assert property (@(posedge ref_clk) disable iff (rst)
      doCapture |=> (curId == $past(pickedId)) && (prevId == $past(curId)) && captured)
      else $error("capture did not shift the store");

   a_hold_unarmed: assert property (@(posedge ref_clk) disable iff (rst)
      (!armed && !loadStrobe && !runningRise) |=> $stable(curId) && $stable(prevId))
      else $error("store changed while channel was off");

   a_disabled_idle: assert property (@(posedge ref_clk) disable iff (rst)
      (!recordEnable && !loadStrobe) |=> $stable(curId) && !captured)
      else $error("capture while recording disabled");

   a_load_both: assert property (@(posedge ref_clk) disable iff (rst)
      loadStrobe |=> (curId == $past(loadId)) && (prevId == $past(loadId)))
      else $error("reload did not fill both slots");
endmodule
`default_nettype wire

/* File: verilog/first_fault_recorder.sv */
// First-fault identifier recorder for two regulated channels
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Separate identifier store for channel A and channel B.
// - A store captures only faults that shut its own channel down.
// - Capture only the earliest flag that disables outputs and restarts with soft start.
// - Flags configured with no action are never captured.
// - Flags that re-enable without soft start are never captured.
// - Store holds current and previous; capture shifts current into previous.
// - Captured identifiers stay held until the next capture or reload; register reads do not clear them.
// - After a capture the store is written to non-volatile memory.
// - On supply-on request the saved identifier fills both current and previous.
// - Further faults while the channel is off change nothing.
// - Flags clearing while the channel stays off leave the store unchanged.
// - Restart does not touch the store but re-arms capture.
// - A qualifying shutdown after restart becomes current, old current becomes previous.
// - Capture only while the recording configuration bit is set.
// - Non-volatile writes only while the same configuration bit is set.
// - Capturable flags: voltage, input sense, current, temperature, external, reverse flags.
// - Actions disable channel A, channel B or all outputs; disable means shutdown.
module first_fault_recorder
   import first_fault_pkg::*;
#(
   parameter int NUM_FLAGS = first_fault_pkg::NUM_FLAGS,
   parameter int ID_W      = first_fault_pkg::ID_W
) (
   input  wire logic                                    ref_clk,              // System clock, 100 MHz
   input  wire logic                                    rst,                  // Async reset, active high
   input  wire logic [NUM_FLAGS-1:0]                    faultFlags,           // Protection flag levels
   input  wire logic [NUM_FLAGS-1:0][1:0]               flagAction,           // Per-flag action code
   input  wire logic [NUM_FLAGS-1:0][1:0]               flagResolve,          // Per-flag resolution code
   input  wire logic                                    chanRunningA,         // Channel A outputs enabled
   input  wire logic                                    chanRunningB,         // Channel B outputs enabled
   input  wire logic                                    supplyOnRequestChanA, // Supply-on pin, channel A
   input  wire logic                                    supplyOnRequestChanB, // Supply-on pin, channel B
   input  wire logic [first_fault_pkg::ADDR_W-1:0]      regAddr,              // Register address
   input  wire logic                                    regRd,                // Read strobe
   input  wire logic                                    regWr,                // Write strobe
   input  wire logic [first_fault_pkg::REG_W-1:0]       regWrData,            // Write data
   output logic      [first_fault_pkg::REG_W-1:0]       regRdData,            // Read data
   output logic                                         regRdValid,           // Read data valid pulse
   output logic                                         nvmReq,               // Non-volatile request
   output logic                                         nvmWe,                // Request is a write
   output logic      [first_fault_pkg::NVM_AW-1:0]      nvmAddr,              // Non-volatile address
   output logic      [first_fault_pkg::REG_W-1:0]       nvmWrData,            // Non-volatile write data
   input  wire logic                                    nvmAck,               // Request done pulse
   input  wire logic [first_fault_pkg::REG_W-1:0]       nvmRdData             // Read data with ack
);
   import first_fault_pkg::*;

   // Pin synchronisers and edge detectors
   logic              sonMetaA;
   logic              sonSyncA;
   logic              sonDlyA;
   logic              sonMetaB;
   logic              sonSyncB;
   logic              sonDlyB;
   logic              sonRiseA;
   logic              sonRiseB;

   // Configuration and qualification
   logic [REG_W-1:0]     cfgReg;
   logic                 recordOn;
   logic [NUM_FLAGS-1:0] qualA;
   logic [NUM_FLAGS-1:0] qualB;

   // Channel stores
   logic [ID_W-1:0]   curA;
   logic [ID_W-1:0]   prevA;
   logic [ID_W-1:0]   curB;
   logic [ID_W-1:0]   prevB;
   logic              capA;
   logic              capB;
   logic [REG_W-1:0]  storeA;
   logic [REG_W-1:0]  storeB;
   logic              loadA;
   logic              loadB;
   logic [ID_W-1:0]   loadId;

   // Non-volatile sequencer
   nvm_state_t        nvState;
   nvm_state_t        next_nvState;
   logic              loadPendA;
   logic              loadPendB;
   logic              storePendA;
   logic              storePendB;
   logic              servingB;
   logic              next_servingB;
   logic              startLoad;
   logic              startStore;
   logic              doneLoad;
   logic              doneStore;

   // Register decode
   logic              hitCfg;
   logic              hitA;
   logic              hitB;
   logic [REG_W-1:0]  next_rdData;

   // Supply-on pins cross from outside through two flops
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sonMetaA <= 1'b0;
         sonSyncA <= 1'b0;
         sonDlyA  <= 1'b0;
         sonMetaB <= 1'b0;
         sonSyncB <= 1'b0;
         sonDlyB  <= 1'b0;
      end else begin
         sonMetaA <= supplyOnRequestChanA;
         sonSyncA <= sonMetaA;
         sonDlyA  <= sonSyncA;
         sonMetaB <= supplyOnRequestChanB;
         sonSyncB <= sonMetaB;
         sonDlyB  <= sonSyncB;
      end
   end

   assign sonRiseA = sonSyncA & ~sonDlyA;
   assign sonRiseB = sonSyncB & ~sonDlyB;

   // Flag qualification per channel, one lane per flag
   genvar g;
   generate
      for (g = 0; g < NUM_FLAGS; g++) begin : gQual
         wire logic softRestart;
         wire logic hitsA;
         wire logic hitsB;
         assign softRestart = (flagResolve[g] != RES_IMMEDIATE);
         assign hitsA = (flagAction[g] == ACT_DIS_A) || (flagAction[g] == ACT_DIS_ALL);
         assign hitsB = (flagAction[g] == ACT_DIS_B) || (flagAction[g] == ACT_DIS_ALL);
         assign qualA[g] = faultFlags[g] & hitsA & softRestart;
         assign qualB[g] = faultFlags[g] & hitsB & softRestart;
      end
   endgenerate

   assign recordOn = cfgReg[CFG_RECORD_BIT];

   // Reload pulses come from the sequencer when a saved byte returns
   assign doneLoad  = (nvState == NV_LOAD) && nvmAck;
   assign doneStore = (nvState == NV_STORE) && nvmAck;
   assign loadA     = doneLoad & ~servingB;
   assign loadB     = doneLoad & servingB;
   assign loadId    = nvmRdData[CUR_LSB +: ID_W];

   // One store per channel
   fault_id_slot #(
      .NUM_FLAGS (NUM_FLAGS),
      .ID_W      (ID_W)
   ) uSlotA (
      .ref_clk        (ref_clk),
      .rst            (rst),
      .recordEnable   (recordOn),
      .channelRunning (chanRunningA),
      .qualify        (qualA),
      .loadStrobe     (loadA),
      .loadId         (loadId),
      .curId          (curA),
      .prevId         (prevA),
      .captured       (capA)
   );

   fault_id_slot #(
      .NUM_FLAGS (NUM_FLAGS),
      .ID_W      (ID_W)
   ) uSlotB (
      .ref_clk        (ref_clk),
      .rst            (rst),
      .recordEnable   (recordOn),
      .channelRunning (chanRunningB),
      .qualify        (qualB),
      .loadStrobe     (loadB),
      .loadId         (loadId),
      .curId          (curB),
      .prevId         (prevB),
      .captured       (capB)
   );

   // Store bytes with current and previous in separate fields
   assign storeA = {prevA, curA};
   assign storeB = {prevB, curB};

   // Pending work; a new event wins over the clear of the same cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         loadPendA  <= 1'b0;
         loadPendB  <= 1'b0;
         storePendA <= 1'b0;
         storePendB <= 1'b0;
      end else begin
         if (sonRiseA) begin
            loadPendA <= 1'b1;
         end else if (startLoad && !next_servingB) begin
            loadPendA <= 1'b0;
         end
         if (sonRiseB) begin
            loadPendB <= 1'b1;
         end else if (startLoad && next_servingB) begin
            loadPendB <= 1'b0;
         end
         if (capA && recordOn) begin
            storePendA <= 1'b1;
         end else if (startStore && !next_servingB) begin
            storePendA <= 1'b0;
         end
         if (capB && recordOn) begin
            storePendB <= 1'b1;
         end else if (startStore && next_servingB) begin
            storePendB <= 1'b0;
         end
      end
   end

   // Sequencer choice: loads before stores, channel A before B
   always_comb begin
      next_nvState  = nvState;
      next_servingB = servingB;
      startLoad     = 1'b0;
      startStore    = 1'b0;
      case (nvState)
         NV_IDLE: begin
            if (loadPendA || loadPendB) begin
               next_nvState  = NV_LOAD;
               next_servingB = ~loadPendA;
               startLoad     = 1'b1;
            end else if (storePendA || storePendB) begin
               next_nvState  = NV_STORE;
               next_servingB = ~storePendA;
               startStore    = 1'b1;
            end
         end
         NV_LOAD: begin
            if (nvmAck) begin
               next_nvState = NV_IDLE;
            end
         end
         NV_STORE: begin
            if (nvmAck) begin
               next_nvState = NV_IDLE;
            end
         end
         default: begin
            next_nvState = NV_IDLE;
         end
      endcase
   end

   // Sequencer state and the request lines held until acknowledge
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         nvState   <= NV_IDLE;
         servingB  <= 1'b0;
         nvmReq    <= 1'b0;
         nvmWe     <= 1'b0;
         nvmAddr   <= NVM_ADDR_A;
         nvmWrData <= '0;
      end else begin
         nvState  <= next_nvState;
         servingB <= next_servingB;
         if (startLoad || startStore) begin
            nvmReq    <= 1'b1;
            nvmWe     <= startStore;
            nvmAddr   <= next_servingB ? NVM_ADDR_B : NVM_ADDR_A;
            nvmWrData <= next_servingB ? storeB : storeA;
         end else if (nvmAck) begin
            nvmReq <= 1'b0;
            nvmWe  <= 1'b0;
         end
      end
   end

   // Register decode and read mux
   assign hitCfg = (regAddr == ADDR_CFG);
   assign hitA   = (regAddr == ADDR_FF_A);
   assign hitB   = (regAddr == ADDR_FF_B);
   assign next_rdData = hitCfg ? cfgReg :
                        hitA   ? storeA :
                        hitB   ? storeB : '0;

   // Configuration write and registered read answer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfgReg     <= CFG_RESET;
         regRdData  <= '0;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRd;
         if (regRd) begin
            regRdData <= next_rdData;
         end
         if (regWr && hitCfg) begin
            cfgReg <= regWrData;
         end
      end
   end

   // Assertion helpers
   sequence sRiseA;
      sonRiseA;
   endsequence

   sequence sLoadPosted;
      ##1 loadPendA;
   endsequence

   a_supply_arms_load: assert property (@(posedge ref_clk) disable iff (rst)
      sRiseA |-> sLoadPosted)
      else $error("supply-on rise did not post a reload");

   a_store_follows: assert property (@(posedge ref_clk) disable iff (rst)
      (capA && recordOn) |=> storePendA || (nvState == NV_STORE))
      else $error("capture did not schedule a write-back");

   a_store_gated: assert property (@(posedge ref_clk) disable iff (rst)
      (!recordOn && !storePendB) |=> !storePendB)
      else $error("write-back scheduled with recording off");

   a_write_data: assert property (@(posedge ref_clk) disable iff (rst)
      (startStore && !next_servingB) |=> nvmReq && nvmWe && (nvmWrData == $past(storeA)))
      else $error("write-back carries wrong byte");

   a_read_store: assert property (@(posedge ref_clk) disable iff (rst)
      (regRd && hitB) |=> regRdValid && (regRdData == $past(storeB)))
      else $error("read of channel B store returned wrong value");

   a_ignore_noaction: assert property (@(posedge ref_clk) disable iff (rst)
      (flagAction[FLG_EXTERNAL] == ACT_NONE) |-> !qualA[FLG_EXTERNAL] && !qualB[FLG_EXTERNAL])
      else $error("flag with no action qualified");

   a_ignore_immediate: assert property (@(posedge ref_clk) disable iff (rst)
      (flagResolve[FLG_OVERVOLT_A] == RES_IMMEDIATE) |-> !qualA[FLG_OVERVOLT_A])
      else $error("flag without soft start qualified");

   a_channel_split: assert property (@(posedge ref_clk) disable iff (rst)
      (qualA != '0 && qualB == '0 && !loadB) |=> $stable(curB))
      else $error("channel B store moved on a channel A fault");

   a_req_held: assert property (@(posedge ref_clk) disable iff (rst)
      (nvmReq && !nvmAck) |=> nvmReq && $stable(nvmAddr))
      else $error("request dropped before acknowledge");
endmodule
`default_nettype wire

/* File: bench/nvm_store_model.sv */
// Behavioural non-volatile byte store on the far side of the recorder
`timescale 1ns/1ps
`default_nettype none
module nvm_store_model #(
   parameter logic [7:0] INIT_A = 8'h00,
   parameter logic [7:0] INIT_B = 8'h00
) (
   input  wire logic       ref_clk,   // System clock
   input  wire logic       rst,       // Async reset
   input  wire logic       nvmReq,    // Request level
   input  wire logic       nvmWe,     // Request is a write
   input  wire logic [7:0] nvmAddr,   // Byte address
   input  wire logic [7:0] nvmWrData, // Write data
   input  wire logic [2:0] lat,       // Answer delay in cycles
   output logic            nvmAck,    // Done pulse
   output logic      [7:0] nvmRdData  // Read data
);
   logic [7:0] mem [2];
   logic [2:0] cnt;
   initial begin
      mem[0] = INIT_A;
      mem[1] = INIT_B;
   end
   // Outside the ack cycle the bus shows the inverse, so a stale read never matches
   assign nvmRdData = nvmAck ? mem[nvmAddr[0]] : ~mem[nvmAddr[0]];
   // Waits the delay, answers once, keeps written bytes
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         nvmAck <= 1'b0;
         cnt <= 3'h0;
      end else if (nvmAck) begin
         nvmAck <= 1'b0;
         cnt <= 3'h0;
      end else if (nvmReq && cnt >= lat) begin
         nvmAck <= 1'b1;
         if (nvmWe) mem[nvmAddr[0]] <= nvmWrData;
      end else if (nvmReq) begin
         cnt <= cnt + 3'h1;
      end
   end
endmodule
`default_nettype wire

/* File: bench/first_fault_recorder_tb.sv */
// Self-checking bench for the first-fault identifier recorder
`timescale 1ns/1ps
`default_nettype none
module first_fault_recorder_tb;
   import first_fault_pkg::*;
   localparam logic [7:0] IA = 8'h35; // Saved byte, channel A
   localparam logic [7:0] IB = 8'h5C; // Saved byte, channel B
   logic                      ref_clk = 1'b0;
   logic                      rst;
   logic [NUM_FLAGS-1:0]      flags;
   logic [NUM_FLAGS-1:0][1:0] act;
   logic [NUM_FLAGS-1:0][1:0] res;
   logic                      runA, runB, sonA, sonB, rRd, rWr, rdV, nReq, nWe, nAck;
   logic [ADDR_W-1:0]         rAddr;
   logic [7:0]                wDat, rDat, nAd, nWd, nRd, d;
   logic [2:0]                lat;
   logic [15:0]               expW[$], obsW[$];
   int nFail, testsRun, nLoad, rec, i, j, a, r;
   int cur[2], prv[2], arm[2] = '{1, 1}, mrun[2], nv[2] = '{IA, IB}, mf[15], ma[15], mr[15];
   always #5 ref_clk = ~ref_clk;
   first_fault_recorder first_fault_recorder_i (
      .ref_clk(ref_clk), .rst(rst), .faultFlags(flags), .flagAction(act), .flagResolve(res),
      .chanRunningA(runA), .chanRunningB(runB), .supplyOnRequestChanA(sonA), .supplyOnRequestChanB(sonB),
      .regAddr(rAddr), .regRd(rRd), .regWr(rWr), .regWrData(wDat), .regRdData(rDat), .regRdValid(rdV),
      .nvmReq(nReq), .nvmWe(nWe), .nvmAddr(nAd), .nvmWrData(nWd), .nvmAck(nAck), .nvmRdData(nRd));
   nvm_store_model #(.INIT_A(IA), .INIT_B(IB)) nvm_store_model_i (
      .ref_clk(ref_clk), .rst(rst), .nvmReq(nReq), .nvmWe(nWe), .nvmAddr(nAd), .nvmWrData(nWd),
      .lat(lat), .nvmAck(nAck), .nvmRdData(nRd));
   // Logs every completed non-volatile transfer
   always @(posedge ref_clk) begin
      if (nReq === 1'b1 && nAck === 1'b1) begin
         if (nWe) obsW.push_back({nAd, nWd});
         else nLoad++;
      end
   end
   task automatic close_out();
      if (nFail == 0 && testsRun > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nFail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Register read: strobe one cycle, data valid one cycle later
   task automatic rd(logic [15:0] ad, string nm, int exp);
      @(posedge ref_clk);
      rRd <= 1'b1;
      rAddr <= ad;
      @(posedge ref_clk);
      rRd <= 1'b0;
      #1;
      chk("rdValid", 16'(rdV), 16'h0001);
      chk(nm, 16'(rDat), 16'(exp));
   endtask
   task automatic wr(logic [7:0] v);
      @(posedge ref_clk);
      rWr <= 1'b1;
      rAddr <= ADDR_CFG;
      wDat <= v;
      @(posedge ref_clk);
      rWr <= 1'b0;
      rec = v[CFG_RECORD_BIT];
   endtask
   // Reference model: lowest qualifying flag of an armed channel becomes current
   task automatic evalm();
      int c, k;
      for (c = 0; c < 2; c++)
         for (k = 0; k < NUM_FLAGS; k++)
            if (rec && arm[c] && mf[k] && (ma[k] == 3 || ma[k] == c + 1) && mr[k] != 0) begin
               prv[c] = cur[c];
               cur[c] = k + 1;
               arm[c] = 0;
               nv[c] = prv[c] * 16 + cur[c];
               expW.push_back({8'(c), 8'(nv[c])});
            end
   endtask
   task automatic setf(int k, int ac, int rs, int v, int sync = 1);
      if (sync) @(posedge ref_clk);
      flags[k] <= v[0];
      act[k] <= ac[1:0];
      res[k] <= rs[1:0];
      mf[k] = v;
      ma[k] = ac;
      mr[k] = rs;
   endtask
   task automatic run(int c, int v);
      @(posedge ref_clk);
      if (c == 0) runA <= v[0];
      else runB <= v[0];
      if (v && !mrun[c]) arm[c] = 1;
      mrun[c] = v;
   endtask
   task automatic cyc();
      run(0, 0);
      run(1, 0);
      run(0, 1);
      run(1, 1);
   endtask
   // Supply-on rise reloads the saved byte's current code into both slots
   task automatic pon(int c);
      int k, n;
      n = nLoad;
      @(posedge ref_clk);
      if (c == 0) sonA <= 1'b1;
      else sonB <= 1'b1;
      for (k = 0; k < 60 && nLoad == n; k++) @(posedge ref_clk);
      if (k == 60) begin
         nFail++;
         close_out();
      end
      cur[c] = nv[c] % 16;
      prv[c] = cur[c];
      arm[c] = 1;
      @(posedge ref_clk);
      sonA <= 1'b0;
      sonB <= 1'b0;
   endtask
   // Compares write-backs and both store bytes against the model
   task automatic settle();
      int k;
      evalm();
      lat <= 3'($urandom_range(0, 4));
      for (k = 0; k < 80 && obsW.size() < expW.size(); k++) @(posedge ref_clk);
      if (k == 80) begin
         nFail++;
         close_out();
      end
      repeat (15) @(posedge ref_clk);
      chk("nvmWrites", 16'(obsW.size()), 16'(expW.size()));
      while (obsW.size() > 0 && expW.size() > 0) chk("nvmWrite", obsW.pop_front(), expW.pop_front());
      expW.delete();
      obsW.delete();
      rd(ADDR_FF_A, "storeA", prv[0] * 16 + cur[0]);
      rd(ADDR_FF_B, "storeB", prv[1] * 16 + cur[1]);
   endtask
   // Main sequence
   initial begin
      {rst, flags, act, res, runA, runB, sonA, sonB, rRd, rWr, rAddr, wDat, lat} = '0;
      rst = 1'b1;
      void'($urandom(54));
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rd(ADDR_CFG, "config", CFG_RESET);
      rd(16'hFE09, "unmapped", 0);
      settle();
      pon(0);
      pon(1);
      settle();
      wr(8'h20);
      rd(ADDR_CFG, "config", 8'h20);
      run(0, 1);
      run(1, 1);
      setf(FLG_INPUT_SENSE, 1, 1, 1);
      settle();
      run(0, 0);
      setf(FLG_OVERTEMP_ONE, 1, 2, 1);
      settle();
      setf(FLG_INPUT_SENSE, 1, 1, 0);
      settle();
      setf(FLG_OVERTEMP_ONE, 1, 2, 0);
      run(0, 1);
      settle();
      setf(FLG_OVERTEMP_ONE, 1, 2, 1);
      settle();
      setf(FLG_OVERTEMP_ONE, 0, 0, 0);
      cyc();
      for (a = 0; a < 4; a++)
         for (r = 0; r < 4; r++) begin
            i = $urandom_range(0, NUM_FLAGS - 1);
            setf(i, a, r, 1);
            settle();
            setf(i, 0, 0, 0);
            cyc();
         end
      i = $urandom_range(0, 6);
      j = i + 1 + $urandom_range(0, 7);
      setf(j, 3, 1, 1);
      setf(i, 3, 1, 1, 0);
      settle();
      setf(j, 0, 0, 0);
      setf(i, 0, 0, 0, 0);
      cyc();
      wr(8'h00);
      rd(ADDR_CFG, "config", 8'h00);
      setf(FLG_EXTERNAL, 3, 1, 1);
      settle();
      setf(FLG_EXTERNAL, 0, 0, 0);
      pon(0);
      settle();
      close_out();
   end
endmodule
`default_nettype wire
